// ==== core/sre_read_engine.sv ====
// Two-wire serial memory read engine with address counter
// Function
// R01 - Address counter holds last accessed location plus one until power loss.
// R02 - Controller opens current-address read: START, matching address, direction 1.
// R03 - On valid read address, acknowledge on ninth clock, then send byte.
// R04 - Counter increments by one after each byte sent.
// R05 - Controller ends single read: no acknowledge on clock 18, then STOP.
// R06 - STOP closing a read returns the engine to standby.
// R07 - Controller acknowledge on clock 18 makes engine send next byte.
// R08 - Engine keeps sending bytes while each one is acknowledged.
// R09 - Counter wraps from highest address to address zero.
// R10 - Controller ends sequential read by withholding acknowledge, then STOP.
// R11 - Dummy write: address byte with direction 0 is acknowledged.
// R12 - Word address of dummy write is acknowledged and loaded into counter.
// R13 - Controller then sends new START and a current-address read.
// R14 - START after dummy write abandons programming and runs the new command.
// R15 - Accept address only if class code and chip-select bits match.
// R16 - Word address arrives as two acknowledged bytes.
// R17 - Counter is thirteen bits; upper word-address bits ignored.
// R18 - Sample on clock rise, change output data after clock fall.
// R19 - Send bytes MSB first; release data line during controller acknowledge.
`timescale 1ns/100ps
module sre_read_engine (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_chip_select_bit_two,
  input wire logic i_chip_select_bit_one,
  input wire logic i_chip_select_bit_zero,
  input wire logic i_wr_bump,
  input wire logic i_mem_valid,
  input wire logic [sre_pkg::DATA_W-1:0] i_mem_data,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_mem_req,
  output logic [sre_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_mem_ready,
  output logic [sre_pkg::ADDR_W-1:0] o_addr_counter,
  output logic o_standby
);

  // ==========================================================
  // Declarations
  sre_pkg::sre_state_e state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [sre_pkg::DATA_W-1:0] shreg_r, shreg_nxt;
  logic [sre_pkg::HI_ADDR_W-1:0] hi_r, hi_nxt;
  logic [sre_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic sda_out_r;
  logic mack_r, mack_nxt;
  logic req_r, req_nxt;
  logic standby_r, standby_nxt;
  logic scl_r, sda_r;
  logic scl_rise, scl_fall;
  logic start_det, stop_det;
  logic addr_load, addr_inc;
  logic [sre_pkg::ADDR_W-1:0] load_val;
  logic pop;
  logic flush;
  logic dev_match;
  logic [sre_pkg::DATA_W-1:0] next_byte;

  sre_fifo_if #(.W(sre_pkg::DATA_W)) fifo_bus ();

  sre_fifo #(
    .W(sre_pkg::DATA_W),
    .DEPTH(sre_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .f(fifo_bus.fifo)
  );

  // ==========================================================
  // FIFO hookup: memory answers fill, shifter drains
  assign fifo_bus.wr_valid = i_mem_valid;
  assign fifo_bus.wr_data = i_mem_data;
  assign fifo_bus.rd_ready = pop;
  assign fifo_bus.flush = flush;
  assign next_byte = fifo_bus.rd_valid ? fifo_bus.rd_data
                                       : sre_pkg::EMPTY_FILL;

  // ==========================================================
  // Bus condition detection
  assign scl_rise = i_scl & ~scl_r;  // [R18]
  assign scl_fall = ~i_scl & scl_r;  // [R18]
  assign start_det = i_scl & scl_r & sda_r & ~i_sda_in;
  assign stop_det = i_scl & scl_r & ~sda_r & i_sda_in;

  // Class code and chip-select comparison
  assign dev_match = (shreg_r[7:4] == sre_pkg::CLASS_CODE) &&
                     (shreg_r[3:1] == {i_chip_select_bit_two,
                                       i_chip_select_bit_one,
                                       i_chip_select_bit_zero});  // [R15]

  // ==========================================================
  // Protocol next state
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shreg_nxt = shreg_r;
    hi_nxt = hi_r;
    sda_oe_nxt = sda_oe_r;
    mack_nxt = mack_r;
    req_nxt = 1'b0;
    addr_load = 1'b0;
    addr_inc = 1'b0;
    load_val = addr_r;
    pop = 1'b0;
    flush = 1'b0;
    if (stop_det) begin
      state_nxt = sre_pkg::ST_IDLE;  // [R06]
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = sre_pkg::ST_DEVADDR;  // [R14]
      bit_cnt_nxt = sre_pkg::BIT_ZERO;
      sda_oe_nxt = 1'b0;
      flush = 1'b1;
    end else begin
      case (state_r)
        sre_pkg::ST_DEVADDR, sre_pkg::ST_WHI, sre_pkg::ST_WLO: begin
          if (scl_rise && bit_cnt_r < sre_pkg::BIT_LAST) begin
            shreg_nxt = sre_pkg::sre_shift_in(shreg_r, i_sda_in);  // [R18]
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == sre_pkg::BIT_LAST) begin
            bit_cnt_nxt = sre_pkg::BIT_ZERO;
            if (state_r == sre_pkg::ST_DEVADDR) begin
              if (!dev_match) begin
                state_nxt = sre_pkg::ST_IDLE;  // [R15]
              end else if (shreg_r[0]) begin
                sda_oe_nxt = 1'b1;  // [R03]
                req_nxt = 1'b1;
                state_nxt = sre_pkg::ST_DEV_ACK_RD;
              end else begin
                sda_oe_nxt = 1'b1;  // [R11]
                state_nxt = sre_pkg::ST_DEV_ACK_WR;
              end
            end else if (state_r == sre_pkg::ST_WHI) begin
              hi_nxt = shreg_r[sre_pkg::HI_ADDR_W-1:0];  // [R17]
              sda_oe_nxt = 1'b1;  // [R16]
              state_nxt = sre_pkg::ST_WHI_ACK;
            end else begin
              addr_load = 1'b1;  // [R12]
              load_val = {hi_r, shreg_r};  // [R16] [R17]
              sda_oe_nxt = 1'b1;
              state_nxt = sre_pkg::ST_WLO_ACK;
            end
          end
        end
        sre_pkg::ST_DEV_ACK_WR: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            state_nxt = sre_pkg::ST_WHI;
          end
        end
        sre_pkg::ST_WHI_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            state_nxt = sre_pkg::ST_WLO;
          end
        end
        sre_pkg::ST_WLO_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            state_nxt = sre_pkg::ST_HOLD;
          end
        end
        sre_pkg::ST_DEV_ACK_RD: begin
          if (scl_fall) begin
            pop = fifo_bus.rd_valid;
            shreg_nxt = next_byte;
            sda_oe_nxt = ~next_byte[7];  // [R19]
            bit_cnt_nxt = sre_pkg::BIT_FIRST;
            state_nxt = sre_pkg::ST_TX;
          end
        end
        sre_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r < sre_pkg::BIT_LAST) begin
              sda_oe_nxt = ~shreg_r[6];  // [R18] [R19]
              shreg_nxt = {shreg_r[6:0], 1'b0};
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end else begin
              sda_oe_nxt = 1'b0;  // [R19]
              addr_inc = 1'b1;  // [R04]
              req_nxt = 1'b1;
              mack_nxt = 1'b1;
              state_nxt = sre_pkg::ST_MACK;
            end
          end
        end
        sre_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_nxt = i_sda_in;
          end else if (scl_fall) begin
            pop = fifo_bus.rd_valid;
            if (!mack_r) begin
              shreg_nxt = next_byte;  // [R07] [R08]
              sda_oe_nxt = ~next_byte[7];
              bit_cnt_nxt = sre_pkg::BIT_FIRST;
              state_nxt = sre_pkg::ST_TX;
            end else begin
              state_nxt = sre_pkg::ST_HOLD;  // [R05] [R10]
            end
          end
        end
        sre_pkg::ST_IDLE, sre_pkg::ST_HOLD: begin
          sda_oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = sre_pkg::ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
    // Counter wraps naturally at thirteen bits
    if (addr_load) begin
      addr_nxt = load_val;
    end else begin
      addr_nxt = addr_r + sre_pkg::ADDR_W'(addr_inc)
                        + sre_pkg::ADDR_W'(i_wr_bump);  // [R01] [R09]
    end
    standby_nxt = (state_nxt == sre_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= sre_pkg::ST_IDLE;
      bit_cnt_r <= sre_pkg::BIT_ZERO;
      shreg_r <= sre_pkg::SHREG_RST;
      hi_r <= '0;
      addr_r <= sre_pkg::ADDR_RST;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      mack_r <= 1'b1;
      req_r <= 1'b0;
      standby_r <= 1'b1;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shreg_r <= shreg_nxt;
      hi_r <= hi_nxt;
      addr_r <= addr_nxt;  // [R01]
      sda_oe_r <= sda_oe_nxt;
      sda_out_r <= 1'b0;
      mack_r <= mack_nxt;
      req_r <= req_nxt;
      standby_r <= standby_nxt;
      scl_r <= i_scl;
      sda_r <= i_sda_in;
    end
  end

  // ==========================================================
  // Outputs
  assign o_sda_out = sda_out_r;
  assign o_sda_oe = sda_oe_r;
  assign o_mem_req = req_r;
  assign o_mem_addr = addr_r;
  assign o_mem_ready = fifo_bus.wr_ready;
  assign o_addr_counter = addr_r;
  assign o_standby = standby_r;

endmodule : sre_read_engine

// ==== core/sre_pkg.sv ====
// Constants, types and helpers shared by the serial read engine
package sre_pkg;

  // ==========================================================
  // Widths and depths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Address byte and framing
  localparam logic [3:0] CLASS_CODE = 4'ha;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam int HI_ADDR_W = ADDR_W - DATA_W;

  // ==========================================================
  // Reset and fill values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] EMPTY_FILL = 8'hff;
  localparam logic [DATA_W-1:0] SHREG_RST = 8'h00;

  // ==========================================================
  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEV_ACK_WR,
    ST_DEV_ACK_RD,
    ST_WHI,
    ST_WHI_ACK,
    ST_WLO,
    ST_WLO_ACK,
    ST_TX,
    ST_MACK,
    ST_HOLD
  } sre_state_e;

  // Shift one received bit in at the low end
  function automatic logic [DATA_W-1:0] sre_shift_in(
    input logic [DATA_W-1:0] cur,
    input logic din
  );
    sre_shift_in = {cur[DATA_W-2:0], din};
  endfunction : sre_shift_in

endpackage : sre_pkg

// ==== core/sre_fifo_if.sv ====
// Valid/ready carrier between the read engine and its data FIFO
`timescale 1ns/100ps
interface sre_fifo_if #(
  parameter int W = 8
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic flush;

  modport fifo (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data
  );
endinterface : sre_fifo_if

// ==== core/sre_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
module sre_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset,
  sre_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ready_r, ready_nxt;
  logic valid_r, valid_nxt;
  logic push;
  logic pop;

  assign push = f.wr_valid & ready_r & ~f.flush;
  assign pop = f.rd_ready & valid_r & ~f.flush;
  assign f.wr_ready = ready_r;
  assign f.rd_valid = valid_r;
  assign f.rd_data = mem_r[rd_ptr_r];

  // ==========================================================
  // Pointer and level update
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (f.flush) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wr_ptr_nxt = wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_nxt = rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_nxt = cnt_r + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_nxt = cnt_r - (AW+1)'(1);
      end
    end
    ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    valid_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
    end
  end

  // Storage, written by index
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= f.wr_data;
    end
  end

endmodule : sre_fifo

// ==== tb/sre_read_engine_monitor.sv ====
// Port-level checks on the serial read engine
`timescale 1ns/100ps
module sre_read_engine_monitor (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_chip_select_bit_two,
  input wire logic i_chip_select_bit_one,
  input wire logic i_chip_select_bit_zero,
  input wire logic i_wr_bump,
  input wire logic i_mem_valid,
  input wire logic [sre_pkg::DATA_W-1:0] i_mem_data,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_mem_req,
  input wire logic [sre_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic o_mem_ready,
  input wire logic [sre_pkg::ADDR_W-1:0] o_addr_counter,
  input wire logic o_standby
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Bus conditions
  sequence stop_seen;
    i_scl && !i_sda_in ##1 i_scl && i_sda_in;
  endsequence
  sequence start_seen;
    i_scl && i_sda_in ##1 i_scl && !i_sda_in;
  endsequence
  // ==========================================================
  // Checks
  reset_vals_a: assert property ($fell(i_reset) |-> o_standby &&
    !o_sda_oe && !o_mem_req && o_mem_addr == 13'h0 && o_mem_ready)
    else $error("state after reset wrong");
  stop_standby_a: assert property (stop_seen |-> ##[1:4] o_standby)
    else $error("no standby after stop");
  start_wake_a: assert property (start_seen |-> ##[1:4] !o_standby)
    else $error("start left engine idle");
  oe_after_fall_a: assert property ($changed(o_sda_oe) |->
    !$past(i_scl) || !$past(i_scl, 2) || !$past(i_scl, 3))
    else $error("data line moved with clock high");
  idle_quiet_a: assert property (o_standby |-> !o_sda_oe && !o_mem_req)
    else $error("activity in standby");
  open_drain_a: assert property (o_sda_out == 1'b0)
    else $error("data output not low");
  addr_mirror_a: assert property (o_mem_addr == o_addr_counter)
    else $error("address outputs differ");
  req_pulse_a: assert property (o_mem_req |=> !o_mem_req)
    else $error("fetch request too long");
  bump_step_a: assert property (o_standby && i_wr_bump |=>
    o_addr_counter == $past(o_addr_counter) + 13'h1)
    else $error("write bump not counted");
  idle_hold_a: assert property (o_standby && !i_wr_bump |=>
    $stable(o_addr_counter)) else $error("counter drifted in standby");
endmodule : sre_read_engine_monitor

bind sre_read_engine sre_read_engine_monitor mon (.i_clk, .i_reset,
  .i_scl, .i_sda_in, .i_chip_select_bit_two, .i_chip_select_bit_one,
  .i_chip_select_bit_zero, .i_wr_bump, .i_mem_valid, .i_mem_data,
  .o_sda_out, .o_sda_oe, .o_mem_req, .o_mem_addr, .o_mem_ready,
  .o_addr_counter, .o_standby);

// ==== tb/sre_ctrl_model.sv ====
// Two-wire bus controller model facing the read engine
`timescale 1ns/100ps
module sre_ctrl_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  localparam int HALF = 16;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ==========================================================
  // Bus phases
  task automatic step(input logic c, input logic l);
    @(posedge i_clk);
    o_scl <= c;
    o_sda_low <= l;
    repeat (HALF - 1) @(posedge i_clk);
  endtask : step
  task automatic start();
    // Clock low first, so an ack still held by the slave is let go
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, o_sda_low);
    step(1'b0, ~b);
    step(1'b1, ~b);
    r = i_sda;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask : xfer
endmodule : sre_ctrl_model

// ==== tb/sre_read_engine_tb.sv ====
// Self-checking bench for the serial read engine
`timescale 1ns/100ps
module sre_read_engine_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bump = 1'b0;
  logic mvld = 1'b0;
  logic [7:0] mdat = 8'h00;
  logic [2:0] cs = 3'h5;
  logic scl, low, oe, sout, req, rdy, stby;
  logic [sre_pkg::ADDR_W-1:0] maddr, cnt;
  wire logic sda = ~(low | oe);
  int num_errors = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  sre_read_engine uut (.i_clk(clk), .i_reset(rst), .i_scl(scl),
    .i_sda_in(sda), .i_chip_select_bit_two(cs[2]),
    .i_chip_select_bit_one(cs[1]), .i_chip_select_bit_zero(cs[0]),
    .i_wr_bump(bump), .i_mem_valid(mvld), .i_mem_data(mdat),
    .o_sda_out(sout), .o_sda_oe(oe), .o_mem_req(req), .o_mem_addr(maddr),
    .o_mem_ready(rdy), .o_addr_counter(cnt), .o_standby(stby));
  sre_ctrl_model ctl (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(low));
  // ==========================================================
  // Memory array stand-in and helpers
  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : pat
  always @(posedge clk) begin
    mvld <= req;
    mdat <= pat(maddr);
  end
  task automatic chk(input string nm, input logic [12:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic stop_idle();
    ctl.stop();
    for (int i = 0; i < 8 && stby !== 1'b1; i++) @(posedge clk);
    chk("standby", 13'(stby), 13'h1);
  endtask : stop_idle
  // ==========================================================
  // Scenarios
  task automatic t_random();
    logic [7:0] d;
    logic a;
    ctl.start();
    ctl.xfer(8'haa, 1'b1, d, a);
    chk("ack_dev_w", 13'(a), 13'h0);
    ctl.xfer(8'hff, 1'b1, d, a);
    chk("ack_hi", 13'(a), 13'h0);
    ctl.xfer(8'hfe, 1'b1, d, a);
    chk("ack_lo", 13'(a), 13'h0);
    chk("cnt_load", cnt, 13'h1ffe);
    ctl.start();
    ctl.xfer(8'hab, 1'b1, d, a);
    chk("ack_dev_r", 13'(a), 13'h0);
    for (int i = 0; i < 3; i++) begin
      ctl.xfer(8'hff, 1'(i == 2), d, a);
      chk("rd", 13'(d), 13'(pat(13'h1ffe + 13'(i))));
    end
    chk("nack_free", 13'(a), 13'h1);
    stop_idle();
    chk("cnt_wrap", cnt, 13'h0001);
  endtask : t_random
  task automatic t_current();
    logic [7:0] d;
    logic a;
    ctl.start();
    ctl.xfer(8'hab, 1'b1, d, a);
    chk("ack_cur", 13'(a), 13'h0);
    ctl.xfer(8'hff, 1'b1, d, a);
    chk("rd_cur", 13'(d), 13'(pat(13'h0001)));
    stop_idle();
    chk("cnt_cur", cnt, 13'h0002);
  endtask : t_current
  task automatic t_bump();
    @(posedge clk) bump <= 1'b1;
    @(posedge clk) bump <= 1'b0;
    repeat (2) @(posedge clk);
    chk("cnt_bump", cnt, 13'h0003);
  endtask : t_bump
  task automatic t_bad();
    logic [7:0] d;
    logic a;
    logic [7:0] bad [2] = '{8'hbb, 8'ha3};
    for (int i = 0; i < 2; i++) begin
      ctl.start();
      ctl.xfer(bad[i], 1'b1, d, a);
      chk("nack_bad", 13'(a), 13'h1);
      chk("stby_bad", 13'(stby), 13'h1);
      stop_idle();
    end
    // Straps moved: chip-select bits 001 now match
    @(posedge clk) cs <= 3'h1;
    ctl.start();
    ctl.xfer(8'ha2, 1'b1, d, a);
    chk("ack_cs", 13'(a), 13'h0);
    stop_idle();
    @(posedge clk) cs <= 3'h5;
    chk("cnt_kept", cnt, 13'h0003);
  endtask : t_bad
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("stby_rst", 13'(stby), 13'h1);
    chk("cnt_rst", cnt, 13'h0000);
    t_random();
    t_current();
    t_bump();
    t_bad();
    end_sim();
  end
endmodule : sre_read_engine_tb
